/* src/bl_zone_consts.vh */
// Register map, field positions and reset values of the backlight zone block
`ifndef BL_ZONE_CONSTS_VH
`define BL_ZONE_CONSTS_VH
// Bus device address, arbitrary value
`define DEV_ADDR_DEFAULT 7'h2a
`define OFS_GEN_CONFIG 8'h10
`define OFS_ZONE_INFO 8'h40
`define OFS_RES_SEL 8'h41
`define OFS_BRIGHTNESS 8'ha0
`define OFS_ZONE_LIMIT0 8'h60
`define OFS_ZONE_TARGET0 8'h70
`define NUM_LIMITS 4
`define NUM_ZONES 5
`define CFG_ALS_EN_BIT 0
`define CFG_CURVE_BIT 1
`define CFG_FS_LSB 2
`define CFG_FS_MSB 4
`define CFG_INPUT_SEL_BIT 5
`define CFG_WIDTH 6
`define ZINFO_FLAG_BIT 3
`define RST_GEN_CONFIG 6'h00
`define RST_RES_SEL 8'h00
`define RST_BRIGHTNESS 7'h00
`define RST_ZONE_LIMITS 32'hcc996633
`define RST_ZONE_TARGETS 35'h7fcd31999
`define LED_CODE_MAX 7'h7f
`define LIN_DIVISOR 23'h00007f
`define FRAC_FULL 23'h00ffff
`define EXP_CODES_PER_OCTAVE 7'h0c
`endif

/* src/two_wire_slave.v */
// Two-wire bus slave turning transfers into register strobes
`timescale 1ns/1ps
`include "bl_zone_consts.vh"
module two_wire_slave #(
    parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
    input wire i_clk,
    input wire i_srst,
    input wire i_scl,
    input wire i_sda,
    output wire o_sda_oe,
    output wire [7:0] o_addr,
    output wire [7:0] o_wdata,
    output wire o_wr_stb,
    output wire o_rd_stb,
    input wire [7:0] i_rdata
);
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_ADDR = 4'h1;
    localparam [3:0] S_ACK_A = 4'h2;
    localparam [3:0] S_PTR = 4'h3;
    localparam [3:0] S_ACK_P = 4'h4;
    localparam [3:0] S_WDATA = 4'h5;
    localparam [3:0] S_ACK_W = 4'h6;
    localparam [3:0] S_RDATA = 4'h7;
    localparam [3:0] S_ACK_R = 4'h8;
    reg scl_r;
    reg sda_r;
    reg [3:0] state_r;
    reg [3:0] cnt_r;
    reg [7:0] sh_r;
    reg [7:0] ptr_r;
    reg [7:0] wdata_r;
    reg oe_r;
    reg rw_r;
    reg mack_r;
    reg wr_r;
    wire scl_rise = i_scl & ~scl_r;
    wire scl_fall = ~i_scl & scl_r;
    wire start = i_scl & scl_r & sda_r & ~i_sda;
    wire stop = i_scl & scl_r & ~sda_r & i_sda;
    // Byte fetch for the host; falling clock edge, opposite the rising-edge data capture
    wire load = scl_fall & ((state_r == S_ACK_A & rw_r) | (state_r == S_ACK_R & mack_r));
    assign o_sda_oe = oe_r;
    assign o_addr = ptr_r;
    assign o_wdata = wdata_r;
    assign o_wr_stb = wr_r;
    assign o_rd_stb = load;
    always @(posedge i_clk) begin
        if (i_srst) begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            state_r <= S_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= 8'h00;
            wdata_r <= 8'h00;
            oe_r <= 1'b0;
            rw_r <= 1'b0;
            mack_r <= 1'b0;
            wr_r <= 1'b0;
        end else begin
            scl_r <= i_scl;
            sda_r <= i_sda;
            wr_r <= 1'b0;
            if (start) begin
                state_r <= S_ADDR;
                cnt_r <= 4'h0;
                oe_r <= 1'b0;
            end else if (stop) begin
                state_r <= S_IDLE;
                oe_r <= 1'b0;
            end else if (scl_rise) begin
                if (state_r == S_ADDR || state_r == S_PTR || state_r == S_WDATA) begin
                    sh_r <= {sh_r[6:0], i_sda};
                    cnt_r <= cnt_r + 4'h1;
                end else if (state_r == S_ACK_R) begin
                    mack_r <= ~i_sda;
                end
            end else if (scl_fall) begin
                case (state_r)
                    S_ADDR: begin
                        if (cnt_r == 4'h8) begin
                            if (sh_r[7:1] == DEV_ADDR) begin
                                oe_r <= 1'b1;
                                rw_r <= sh_r[0];
                                state_r <= S_ACK_A;
                            end else begin
                                state_r <= S_IDLE;
                            end
                        end
                    end
                    S_PTR: begin
                        if (cnt_r == 4'h8) begin
                            ptr_r <= sh_r;
                            oe_r <= 1'b1;
                            state_r <= S_ACK_P;
                        end
                    end
                    S_WDATA: begin
                        if (cnt_r == 4'h8) begin
                            wdata_r <= sh_r;
                            wr_r <= 1'b1;
                            oe_r <= 1'b1;
                            state_r <= S_ACK_W;
                        end
                    end
                    S_ACK_A, S_ACK_R: begin
                        cnt_r <= 4'h0;
                        if (load) begin
                            sh_r <= i_rdata;
                            oe_r <= ~i_rdata[7];
                            state_r <= S_RDATA;
                        end else begin
                            oe_r <= 1'b0;
                            state_r <= (state_r == S_ACK_A) ? S_PTR : S_IDLE;
                        end
                    end
                    S_ACK_P, S_ACK_W: begin
                        oe_r <= 1'b0;
                        cnt_r <= 4'h0;
                        if (state_r == S_ACK_W) begin
                            ptr_r <= ptr_r + 8'h01;
                        end
                        state_r <= S_WDATA;
                    end
                    S_RDATA: begin
                        if (cnt_r == 4'h7) begin
                            oe_r <= 1'b0;
                            ptr_r <= ptr_r + 8'h01;
                            state_r <= S_ACK_R;
                        end else begin
                            cnt_r <= cnt_r + 4'h1;
                            sh_r <= {sh_r[6:0], 1'b0};
                            oe_r <= ~sh_r[6];
                        end
                    end
                    default: begin
                        state_r <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // two_wire_slave

/* src/bl_zone_regs.v */
// Register bank, zone detection and LED current mapping of the backlight driver
// Summary of operation
// R1: Low nibble picks sensor A resistance
// R2: High nibble picks sensor B resistance
// R3: Zero low nibble leaves sensor A floating
// R4: Zero high nibble leaves sensor B floating
// R5: Seven-bit brightness code, top bit unused
// R6: Code scaled against selected full-scale current
// R7: Curve bit zero selects exponential mapping
// R8: Curve bit one selects linear mapping
// R9: Linear code one is 1/127; zero is off
// R10: Code 127 gives exact full scale
// R11: Zone limits reset to 200/400/600/800 mV
// R12: Host keeps zone limits strictly increasing
// R13: Five zone targets hold brightness codes
// R14: Zone targets reset 0x19,0x33,0x4c,0x66,0x7f
// R15: Sensor level classified into zones 0..4
// R16: Zone info register tracks new zone
// R17: Zone change flags and pulls interrupt; read clears
// R18: Ambient mode drives current from zone target
`timescale 1ns/1ps
`include "bl_zone_consts.vh"
module bl_zone_regs #(
    parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
    input wire i_clk,
    input wire i_srst,
    input wire i_scl,
    input wire i_sda,
    output wire o_sda_out,
    output wire o_sda_oe,
    input wire [7:0] i_sensor_a_level,
    input wire [7:0] i_sensor_b_level,
    output wire [3:0] o_sensor_a_res_sel,
    output wire o_sensor_a_hiz,
    output wire [3:0] o_sensor_b_res_sel,
    output wire o_sensor_b_hiz,
    output wire [2:0] o_full_scale_sel,
    output wire o_curve_linear,
    output wire [6:0] o_led_code,
    output wire [15:0] o_led_current_frac,
    output wire o_leds_off,
    output wire [2:0] o_zone_code,
    output wire o_int_out,
    output wire o_int_oe
);
    localparam [31:0] LIM_RST = `RST_ZONE_LIMITS;
    localparam [34:0] TGT_RST = `RST_ZONE_TARGETS;

    wire wr_stb;
    wire rd_stb;
    wire [7:0] bus_addr;
    wire [7:0] bus_wdata;
    reg [7:0] rdata;

    reg [`CFG_WIDTH-1:0] cfg_r;
    reg [7:0] res_sel_r;
    reg [6:0] brt_r;
    reg [2:0] zone_r;
    reg flag_r;
    reg hiz_a_r;
    reg hiz_b_r;
    reg [6:0] code_r;
    reg [15:0] frac_r;
    reg off_r;
    reg sda_zero_r;

    wire [31:0] lim_vec;
    wire [34:0] tgt_vec;
    wire [3:0] below;
    reg [2:0] zone_now;
    reg [6:0] code_nxt;
    reg [15:0] frac_nxt;
    wire [7:0] lim_ofs = bus_addr - `OFS_ZONE_LIMIT0;
    wire [7:0] tgt_ofs = bus_addr - `OFS_ZONE_TARGET0;
    wire als_en = cfg_r[`CFG_ALS_EN_BIT];
    wire curve_lin = cfg_r[`CFG_CURVE_BIT];
    wire [7:0] level = cfg_r[`CFG_INPUT_SEL_BIT] ? i_sensor_b_level : i_sensor_a_level;
    wire zone_change = als_en && (zone_now != zone_r);
    wire info_read = rd_stb && (bus_addr == `OFS_ZONE_INFO);

    two_wire_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_bus (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_sda_oe(o_sda_oe),
        .o_addr(bus_addr),
        .o_wdata(bus_wdata),
        .o_wr_stb(wr_stb),
        .o_rd_stb(rd_stb),
        .i_rdata(rdata)
    );

    // Linear curve: code/127 of full scale, exact at both ends
    function [15:0] lin_frac;
        input [6:0] code;
        reg [22:0] prod;
        reg [22:0] quot;
        begin
            prod = {16'h0000, code} * `FRAC_FULL;
            quot = prod / `LIN_DIVISOR;
            lin_frac = quot[15:0];
        end
    endfunction

    // Exponential curve: one octave every twelve codes below full scale
    function [15:0] exp_frac;
        input [6:0] code;
        reg [6:0] e;
        reg [6:0] oct;
        reg [6:0] step;
        reg [15:0] mant;
        begin
            e = `LED_CODE_MAX - code;
            oct = e / `EXP_CODES_PER_OCTAVE;
            step = e % `EXP_CODES_PER_OCTAVE;
            case (step[3:0])
                4'h0: mant = 16'hffff;
                4'h1: mant = 16'hf1a2;
                4'h2: mant = 16'he412;
                4'h3: mant = 16'hd745;
                4'h4: mant = 16'hcb30;
                4'h5: mant = 16'hbfc9;
                4'h6: mant = 16'hb505;
                4'h7: mant = 16'haadc;
                4'h8: mant = 16'ha145;
                4'h9: mant = 16'h9838;
                4'ha: mant = 16'h8fad;
                4'hb: mant = 16'h879c;
                default: mant = 16'h0000;
            endcase
            exp_frac = mant >> oct;
        end
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_LIMITS; gi = gi + 1) begin : g_lim
            localparam integer ADDR_I = `OFS_ZONE_LIMIT0 + gi;
            reg [7:0] val_r;
            always @(posedge i_clk) begin
                if (i_srst) begin
                    val_r <= LIM_RST[gi*8 +: 8]; // R11
                end else if (wr_stb && bus_addr == ADDR_I[7:0]) begin
                    val_r <= bus_wdata;
                end
            end
            assign lim_vec[gi*8 +: 8] = val_r;
            assign below[gi] = level < val_r; // R15
        end
        for (gi = 0; gi < `NUM_ZONES; gi = gi + 1) begin : g_tgt
            localparam integer ADDR_I = `OFS_ZONE_TARGET0 + gi;
            reg [6:0] val_r;
            always @(posedge i_clk) begin
                if (i_srst) begin
                    val_r <= TGT_RST[gi*7 +: 7]; // R14
                end else if (wr_stb && bus_addr == ADDR_I[7:0]) begin
                    val_r <= bus_wdata[6:0]; // R13
                end
            end
            assign tgt_vec[gi*7 +: 7] = val_r;
        end
    endgenerate

    // Lowest-numbered limit above the level wins, so a misordered table still decodes
    always @* begin
        if (below[0]) begin
            zone_now = 3'h0; // R15
        end else if (below[1]) begin
            zone_now = 3'h1;
        end else if (below[2]) begin
            zone_now = 3'h2;
        end else if (below[3]) begin
            zone_now = 3'h3;
        end else begin
            zone_now = 3'h4;
        end
    end

    always @* begin
        rdata = 8'h00;
        case (bus_addr)
            `OFS_GEN_CONFIG: begin
                rdata = {2'b00, cfg_r};
            end
            `OFS_ZONE_INFO: begin
                rdata = {4'h0, flag_r, zone_r}; // R16
            end
            `OFS_RES_SEL: begin
                rdata = res_sel_r;
            end
            `OFS_BRIGHTNESS: begin
                rdata = {1'b0, brt_r}; // R5
            end
            default: begin
                if (lim_ofs < 8'h04) begin
                    rdata = lim_vec[lim_ofs[1:0]*8 +: 8];
                end else if (tgt_ofs < 8'h05) begin
                    rdata = {1'b0, tgt_vec[tgt_ofs[2:0]*7 +: 7]};
                end
            end
        endcase
    end

    always @* begin
        if (als_en) begin
            code_nxt = tgt_vec[zone_r*7 +: 7]; // R18
        end else begin
            code_nxt = brt_r; // R5
        end
        if (code_nxt == 7'h00) begin
            frac_nxt = 16'h0000; // R9
        end else if (curve_lin) begin
            frac_nxt = lin_frac(code_nxt); // R8 R9 R10
        end else begin
            frac_nxt = exp_frac(code_nxt); // R7 R10
        end
    end

    always @(posedge i_clk) begin
        if (i_srst) begin
            cfg_r <= `RST_GEN_CONFIG;
            res_sel_r <= `RST_RES_SEL;
            brt_r <= `RST_BRIGHTNESS;
        end else if (wr_stb) begin
            case (bus_addr)
                `OFS_GEN_CONFIG: begin
                    cfg_r <= bus_wdata[`CFG_WIDTH-1:0]; // R6 R7 R8
                end
                `OFS_RES_SEL: begin
                    res_sel_r <= bus_wdata; // R1 R2
                end
                `OFS_BRIGHTNESS: begin
                    brt_r <= bus_wdata[6:0]; // R5
                end
                default: begin
                end
            endcase
        end
    end

    // New zone sets the flag; a set in the clearing cycle wins
    always @(posedge i_clk) begin
        if (i_srst) begin
            zone_r <= 3'h0;
            flag_r <= 1'b0;
        end else begin
            if (zone_change) begin
                zone_r <= zone_now; // R16
            end
            flag_r <= zone_change | (flag_r & ~info_read); // R17
        end
    end

    always @(posedge i_clk) begin
        if (i_srst) begin
            hiz_a_r <= 1'b1;
            hiz_b_r <= 1'b1;
            code_r <= 7'h00;
            frac_r <= 16'h0000;
            off_r <= 1'b1;
            sda_zero_r <= 1'b0;
        end else begin
            hiz_a_r <= (res_sel_r[3:0] == 4'h0); // R3
            hiz_b_r <= (res_sel_r[7:4] == 4'h0); // R4
            code_r <= code_nxt;
            frac_r <= frac_nxt; // R6
            off_r <= (code_nxt == 7'h00); // R9
            sda_zero_r <= 1'b0;
        end
    end

    assign o_sda_out = sda_zero_r;
    assign o_sensor_a_res_sel = res_sel_r[3:0]; // R1
    assign o_sensor_a_hiz = hiz_a_r;
    assign o_sensor_b_res_sel = res_sel_r[7:4]; // R2
    assign o_sensor_b_hiz = hiz_b_r;
    assign o_full_scale_sel = cfg_r[`CFG_FS_MSB:`CFG_FS_LSB]; // R6
    assign o_curve_linear = curve_lin;
    assign o_led_code = code_r;
    assign o_led_current_frac = frac_r;
    assign o_leds_off = off_r;
    assign o_zone_code = zone_r;
    // Open-drain interrupt: pulled low while the flag stands
    assign o_int_out = sda_zero_r;
    assign o_int_oe = flag_r; // R17

endmodule // bl_zone_regs

/* verification/bl_zone_regs_chk.sv */
// Port-level assertions for the backlight zone register block
`timescale 1ns/1ps
module bl_zone_regs_chk (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_scl,
    input wire logic [3:0] o_sensor_a_res_sel,
    input wire logic o_sensor_a_hiz,
    input wire logic [3:0] o_sensor_b_res_sel,
    input wire logic o_sensor_b_hiz,
    input wire logic o_curve_linear,
    input wire logic [6:0] o_led_code,
    input wire logic [15:0] o_led_current_frac,
    input wire logic o_leds_off,
    input wire logic [2:0] o_zone_code,
    input wire logic o_int_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    property p_a_floats;
        $stable(o_sensor_a_res_sel) |-> o_sensor_a_hiz == ($past(o_sensor_a_res_sel) == 4'h0);
    endproperty
    a_a_floats: assert property (p_a_floats) else $error("sensor a float wrong");
    property p_b_floats;
        $stable(o_sensor_b_res_sel) |-> o_sensor_b_hiz == ($past(o_sensor_b_res_sel) == 4'h0);
    endproperty
    a_b_floats: assert property (p_b_floats) else $error("sensor b float wrong");
    property p_off_flag;
        $stable(o_led_code) |-> o_leds_off == ($past(o_led_code) == 7'h00);
    endproperty
    a_off_flag: assert property (p_off_flag) else $error("leds off flag wrong");
    property p_off_frac;
        (o_led_code == 7'h00) [*3] |-> o_led_current_frac == 16'h0000;
    endproperty
    a_off_frac: assert property (p_off_frac) else $error("code zero not dark");
    property p_full;
        (o_led_code == 7'h7f) [*3] |-> o_led_current_frac == 16'hffff;
    endproperty
    a_full: assert property (p_full) else $error("top code not full scale");
    property p_lin_one;
        (o_curve_linear && o_led_code == 7'h01) [*3] |-> o_led_current_frac == 16'h0204;
    endproperty
    a_lin_one: assert property (p_lin_one) else $error("linear step wrong");
    property p_exp_one;
        (!o_curve_linear && o_led_code == 7'h01) [*3] |-> o_led_current_frac == 16'h002d;
    endproperty
    a_exp_one: assert property (p_exp_one) else $error("exponential step wrong");
    property p_zone_range;
        o_zone_code <= 3'd4;
    endproperty
    a_zone_range: assert property (p_zone_range) else $error("zone code out of range");
    property p_int_set;
        !$stable(o_zone_code) |-> o_int_oe;
    endproperty
    a_int_set: assert property (p_int_set) else $error("zone change not flagged");
    property p_int_hold;
        o_int_oe && !i_scl && !$past(i_scl) |=> o_int_oe;
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("flag dropped without read");
endmodule // bl_zone_regs_chk
bind bl_zone_regs bl_zone_regs_chk chk (.i_clk(i_clk), .i_srst(i_srst), .i_scl(i_scl),
    .o_sensor_a_res_sel(o_sensor_a_res_sel), .o_sensor_a_hiz(o_sensor_a_hiz),
    .o_sensor_b_res_sel(o_sensor_b_res_sel), .o_sensor_b_hiz(o_sensor_b_hiz),
    .o_curve_linear(o_curve_linear), .o_led_code(o_led_code),
    .o_led_current_frac(o_led_current_frac), .o_leds_off(o_leds_off),
    .o_zone_code(o_zone_code), .o_int_oe(o_int_oe));

/* verification/host_bus_model.sv */
// Two-wire bus master model acting as the host processor
`timescale 1ns/1ps
module host_bus_model #(
    parameter [6:0] DEV_ADDR = 7'h2a
) (
    input wire i_clk,
    input wire i_sda,
    output reg o_scl = 1'b1,
    output reg o_sda_oe = 1'b0
);
    reg [7:0] rd_buf [0:7];
    integer acks_missed = 0;
    task automatic tick(input integer n);
        begin
            repeat (n) @(posedge i_clk);
            #1;
        end
    endtask
    task automatic put_bit(input reg b);
        begin
            o_sda_oe = ~b;
            tick(2);
            o_scl = 1'b1;
            tick(4);
            o_scl = 1'b0;
            tick(2);
        end
    endtask
    task automatic get_bit(output reg b);
        begin
            o_sda_oe = 1'b0;
            tick(2);
            o_scl = 1'b1;
            tick(2);
            b = i_sda;
            tick(2);
            o_scl = 1'b0;
            tick(2);
        end
    endtask
    // Also serves as repeated start when the clock line is low
    task automatic start_cond;
        begin
            o_sda_oe = 1'b0;
            tick(2);
            o_scl = 1'b1;
            tick(4);
            o_sda_oe = 1'b1;
            tick(4);
            o_scl = 1'b0;
            tick(2);
        end
    endtask
    task automatic stop_cond;
        begin
            o_sda_oe = 1'b1;
            tick(2);
            o_scl = 1'b1;
            tick(4);
            o_sda_oe = 1'b0;
            tick(4);
        end
    endtask
    task automatic byte_out(input reg [7:0] d);
        integer i;
        reg a;
        begin
            for (i = 7; i >= 0; i = i - 1) put_bit(d[i]);
            get_bit(a);
            if (a) acks_missed = acks_missed + 1;
        end
    endtask
    task automatic write_reg(input reg [7:0] ofs, input reg [7:0] d);
        begin
            start_cond;
            byte_out({DEV_ADDR, 1'b0});
            byte_out(ofs);
            byte_out(d);
            stop_cond;
        end
    endtask
    // Master acknowledges every byte but the last
    task automatic read_regs(input reg [7:0] ofs, input integer n);
        integer i;
        integer k;
        begin
            start_cond;
            byte_out({DEV_ADDR, 1'b0});
            byte_out(ofs);
            start_cond;
            byte_out({DEV_ADDR, 1'b1});
            for (k = 0; k < n; k = k + 1) begin
                for (i = 7; i >= 0; i = i - 1) get_bit(rd_buf[k][i]);
                put_bit(k == n - 1);
            end
            stop_cond;
        end
    endtask
endmodule // host_bus_model

/* verification/tb_top.sv */
// Self-checking bench for the backlight zone register block
`timescale 1ns/1ps
`include "bl_zone_consts.vh"
`define CHK(got, exp) begin n_tests = n_tests + 1; if ((got) !== (exp)) begin \
num_errors = num_errors + 1; $display("unexpected at %0t: got %h exp %h", $time, got, exp); end end
module tb_top;
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg [7:0] lvl_a = 8'h00;
    reg [7:0] lvl_b = 8'h00;
    wire scl;
    wire host_oe;
    wire dut_oe;
    wire sda = ~(host_oe | dut_oe);
    wire [3:0] res_a;
    wire [3:0] res_b;
    wire hiz_a;
    wire hiz_b;
    wire [2:0] fs_sel;
    wire lin;
    wire [6:0] code;
    wire [15:0] frac;
    wire off;
    wire [2:0] zone;
    wire int_oe;
    wire sda_out;
    wire int_out;
    integer num_errors = 0;
    integer n_tests = 0;
    integer k;
    reg [7:0] tgt [0:4] = '{8'h19, 8'h33, 8'h4c, 8'h66, 8'h7f};
    reg [7:0] v [0:3] = '{8'h00, 8'h05, 8'ha0, 8'hf1};
    // Config, code, expected fraction
    reg [31:0] cv [0:4] = '{32'h1e010204, 32'h0001002d, 32'h0c7fffff, 32'h167fffff, 32'h02000000};
    reg [7:0] lv [0:4] = '{8'h10, 8'h2f, 8'h30, 8'hff, 8'h05};
    always #50 clk = ~clk;
    host_bus_model host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));
    bl_zone_regs dut (.i_clk(clk), .i_srst(srst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
        .o_sda_oe(dut_oe), .i_sensor_a_level(lvl_a), .i_sensor_b_level(lvl_b),
        .o_sensor_a_res_sel(res_a), .o_sensor_a_hiz(hiz_a), .o_sensor_b_res_sel(res_b),
        .o_sensor_b_hiz(hiz_b), .o_full_scale_sel(fs_sel), .o_curve_linear(lin),
        .o_led_code(code), .o_led_current_frac(frac), .o_leds_off(off), .o_zone_code(zone),
        .o_int_out(int_out), .o_int_oe(int_oe));
    task tally_and_finish;
        begin
            $display("errors %0d checks %0d", num_errors, n_tests);
            if (num_errors == 0 && n_tests > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        num_errors = num_errors + 1;
        tally_and_finish;
    end
    initial begin
        repeat (3) @(posedge clk);
        #1;
        srst = 1'b0;
        host.tick(1);
        `CHK(hiz_a, 1'b1)
        `CHK(hiz_b, 1'b1)
        host.read_regs(`OFS_ZONE_LIMIT0, 4);
        for (k = 0; k < 4; k = k + 1) `CHK(host.rd_buf[k], 8'(8'h33 * (k + 1)))
        host.read_regs(`OFS_ZONE_TARGET0, 5);
        for (k = 0; k < 5; k = k + 1) `CHK(host.rd_buf[k], tgt[k])
        host.read_regs(8'h20, 1);
        `CHK(host.rd_buf[0], 8'h00)
        for (k = 0; k < 4; k = k + 1) begin
            host.write_reg(`OFS_RES_SEL, v[k]);
            host.tick(3);
            `CHK(res_a, v[k][3:0])
            `CHK(res_b, v[k][7:4])
            `CHK(hiz_a, v[k][3:0] == 4'h0)
            `CHK(hiz_b, v[k][7:4] == 4'h0)
        end
        host.write_reg(`OFS_BRIGHTNESS, 8'hff);
        host.read_regs(`OFS_BRIGHTNESS, 1);
        `CHK(host.rd_buf[0], 8'h7f)
        `CHK(code, 7'h7f)
        for (k = 0; k < 5; k = k + 1) begin
            host.write_reg(`OFS_GEN_CONFIG, cv[k][31:24]);
            host.write_reg(`OFS_BRIGHTNESS, cv[k][23:16]);
            host.tick(4);
            `CHK(fs_sel, cv[k][28:26])
            `CHK(lin, cv[k][25])
            `CHK(frac, cv[k][15:0])
            `CHK(off, cv[k][23:16] == 8'h00)
        end
        for (k = 0; k < 4; k = k + 1) host.write_reg(8'(`OFS_ZONE_LIMIT0 + k), 8'(8'h10 * (k + 1)));
        tgt[4] = 8'h55;
        host.write_reg(8'(`OFS_ZONE_TARGET0 + 4), tgt[4]);
        host.write_reg(`OFS_GEN_CONFIG, 8'h01);
        for (k = 0; k < 5; k = k + 1) begin
            lvl_a = lv[k];
            host.tick(4);
            `CHK(zone, 3'((k + 1) % 5))
            `CHK(int_oe, 1'b1)
            `CHK(int_out, 1'b0)
            `CHK(code, tgt[(k + 1) % 5][6:0])
            host.read_regs(`OFS_ZONE_INFO, 1);
            `CHK(host.rd_buf[0], 8'(8'h08 + (k + 1) % 5))
            `CHK(int_oe, 1'b0)
        end
        lvl_b = 8'h25;
        host.write_reg(`OFS_GEN_CONFIG, 8'h21);
        host.tick(2);
        `CHK(zone, 3'd2)
        host.read_regs(`OFS_ZONE_INFO, 1);
        `CHK(host.rd_buf[0], 8'h0a)
        host.write_reg(`OFS_GEN_CONFIG, 8'h00);
        lvl_b = 8'hff;
        host.tick(4);
        `CHK(zone, 3'd2)
        `CHK(code, 7'h00)
        `CHK(host.acks_missed, 0)
        `CHK(sda_out, 1'b0)
        tally_and_finish;
    end
endmodule // tb_top
